// [design/smc_standby_ctrl.sv]
// Overview of operation
// - Sleep with request bit enters selected mode
// - IDLE exits on interrupt, NMI or reset
// - Wake only when level above mask level
// - Halt freezes core, holds bus mastership
// - Doze freezes core, bus requests still served
// - STOP exits on lines, NMI, reset; not watchdog
// - Line wakes STOP only if enabled
// - Halt stops DMA; Doze keeps DMA running
// - STOP gates oscillator, CPU and peripheral clocks
// - Mode and wake enable settings apply after keys within 64 cycles
// - Watchdog counter held during STOP, not cleared
//
// The address map and the APB slave port were left to the implementer.
module smc_standby_ctrl (
  input wire logic clk,               // System clock, 200 MHz
  input wire logic rst_n,             // Asynchronous reset, active low
  input wire logic psel,              // APB select
  input wire logic penable,           // APB access phase
  input wire logic pwrite,            // APB direction
  input wire logic [7:0] paddr,       // APB byte address
  input wire logic [31:0] pwdata,     // APB write data
  output logic pready,                // APB ready
  output logic pslverr,               // APB error, unmapped address
  output logic [31:0] prdata,         // APB read data
  input wire logic standbyReqBit,     // Core standby request bit
  input wire logic sleepExec,         // Sleep instruction executed
  input wire logic intReq,            // Interrupt controller request
  input wire logic [2:0] intLevel,    // Level of that request
  input wire logic nmiReq,            // Nonmaskable interrupt
  input wire logic nmiFromWdt,        // NMI raised by watchdog
  input wire logic rstReq,            // Reset request
  input wire logic rstFromWdt,        // Reset raised by watchdog
  input wire logic [3:0] extIntLine,  // External interrupt pins
  output logic cpuClkEn,              // Core clock enable
  output logic dmaClkEn,              // DMA clock enable
  output logic perClkEn,              // Peripheral clock enable
  output logic oscEn,                 // Oscillator enable
  output logic busHold,               // Ignore external bus requests
  output logic wdtHold,               // Freeze watchdog counter
  output logic serviceGo              // Core may service, one pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  smc_pkg::smc_regs_s r_ff;
  smc_pkg::smc_regs_s nxt_r;
  logic accessWr;
  logic idleWake;
  logic stopWake;
  logic extHit;
  logic key2Hit;

  // ----------------------------------------------------------------
  // Wake decoding
  // ----------------------------------------------------------------
  // Strict greater-than: an equal level never wakes
  always_comb
  begin
    extHit = 1'b0;
    for (int i = 0; i < smc_pkg::LINES; i++)
    begin
      if (r_ff.lineVal[i] && r_ff.appWake[i] &&
          (r_ff.lineLvl[i*smc_pkg::LVL_W +: smc_pkg::LVL_W] > r_ff.maskLvl))
      begin
        extHit = 1'b1;
      end
    end
    idleWake = (intReq && (intLevel > r_ff.maskLvl)) || nmiReq || rstReq;
    // Watchdog sources sleep through STOP, its clock is gone
    stopWake = extHit || (nmiReq && !nmiFromWdt) || (rstReq && !rstFromWdt);
  end

  assign accessWr = psel && penable && r_ff.pready && pwrite;
  assign key2Hit = accessWr && (paddr == smc_pkg::ADDR_UNLOCK) &&
                   (pwdata[15:0] == smc_pkg::KEY_SECOND) && r_ff.keyStage && r_ff.winOpen;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_r = r_ff;
    // Three-stage pin sync; a change counts when stages two and three agree
    nxt_r.sync1 = extIntLine;
    nxt_r.sync2 = r_ff.sync1;
    nxt_r.sync3 = r_ff.sync2;
    for (int j = 0; j < smc_pkg::LINES; j++)
    begin
      if (r_ff.sync2[j] == r_ff.sync3[j])
      begin
        nxt_r.lineVal[j] = r_ff.sync3[j];
      end
    end

    // Unlock window counts down and discards late keys
    if (r_ff.winOpen)
    begin
      if (r_ff.winCnt == 7'h00)
      begin
        nxt_r.winOpen = 1'b0;
        nxt_r.keyStage = 1'b0;
      end
      else
      begin
        nxt_r.winCnt = r_ff.winCnt - 7'h01;
      end
    end

    // APB: answer in the first access cycle, write lands on that edge
    nxt_r.pready = psel && !penable;
    nxt_r.pslverr = 1'b0;
    nxt_r.prdata = 32'h0000_0000;
    if (psel && !penable)
    begin
      case (paddr)
        smc_pkg::ADDR_MODE: nxt_r.prdata = {30'h0, r_ff.appMode};
        smc_pkg::ADDR_UNLOCK: nxt_r.prdata = 32'h0000_0000;
        smc_pkg::ADDR_WAKE: nxt_r.prdata = {28'h0, r_ff.appWake};
        smc_pkg::ADDR_MASK: nxt_r.prdata = {29'h0, r_ff.maskLvl};
        smc_pkg::ADDR_LEVEL: nxt_r.prdata = {20'h0, r_ff.lineLvl};
        smc_pkg::ADDR_STATUS: nxt_r.prdata = {21'h0, r_ff.st, 4'h0, r_ff.lineVal};
        default: nxt_r.pslverr = 1'b1;
      endcase
    end
    if (accessWr)
    begin
      case (paddr)
        smc_pkg::ADDR_MODE, smc_pkg::ADDR_WAKE:
        begin
          // Staged only; the key sequence must follow within the window
          if (paddr == smc_pkg::ADDR_MODE)
          begin
            nxt_r.pendMode = pwdata[1:0];
          end
          else
          begin
            nxt_r.pendWake = pwdata[3:0];
          end
          nxt_r.winOpen = 1'b1;
          nxt_r.winCnt = smc_pkg::UNLOCK_WINDOW;
          nxt_r.keyStage = 1'b0;
        end
        smc_pkg::ADDR_UNLOCK:
        begin
          nxt_r.keyStage = r_ff.winOpen && (pwdata[15:0] == smc_pkg::KEY_FIRST);
          if (key2Hit)
          begin
            nxt_r.appMode = r_ff.pendMode;
            nxt_r.appWake = r_ff.pendWake;
            nxt_r.winOpen = 1'b0;
          end
        end
        smc_pkg::ADDR_MASK: nxt_r.maskLvl = pwdata[2:0];
        smc_pkg::ADDR_LEVEL: nxt_r.lineLvl = pwdata[11:0];
        default: nxt_r.maskLvl = r_ff.maskLvl;
      endcase
    end

    // Mode sequencer
    nxt_r.serviceGo = 1'b0;
    case (r_ff.st)
      smc_pkg::ST_NORMAL:
      begin
        if (sleepExec && standbyReqBit)
        begin
          case (r_ff.appMode)
            smc_pkg::MODE_STOP: nxt_r.st = smc_pkg::ST_STOP;
            smc_pkg::MODE_HALT: nxt_r.st = smc_pkg::ST_HALT;
            smc_pkg::MODE_DOZE: nxt_r.st = smc_pkg::ST_DOZE;
            default: nxt_r.st = smc_pkg::ST_NORMAL;
          endcase
        end
      end
      smc_pkg::ST_HALT, smc_pkg::ST_DOZE:
      begin
        if (idleWake)
        begin
          nxt_r.st = smc_pkg::ST_WAKE;
        end
      end
      smc_pkg::ST_STOP:
      begin
        if (stopWake)
        begin
          nxt_r.st = smc_pkg::ST_WAKE;
        end
      end
      smc_pkg::ST_WAKE:
      begin
        // Clocks came back last cycle; only now release the core
        nxt_r.st = smc_pkg::ST_NORMAL;
        nxt_r.serviceGo = 1'b1;
      end
      default: nxt_r.st = smc_pkg::ST_NORMAL;
    endcase

    // Clock and bus controls follow the next state
    nxt_r.cpuClkEn = (nxt_r.st == smc_pkg::ST_NORMAL) || (nxt_r.st == smc_pkg::ST_WAKE);
    nxt_r.dmaClkEn = !(nxt_r.st inside {smc_pkg::ST_HALT, smc_pkg::ST_STOP});
    nxt_r.perClkEn = (nxt_r.st != smc_pkg::ST_STOP);
    nxt_r.oscEn = (nxt_r.st != smc_pkg::ST_STOP);
    nxt_r.busHold = (nxt_r.st == smc_pkg::ST_HALT);
    nxt_r.wdtHold = (nxt_r.st == smc_pkg::ST_STOP);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_ff <= '0;
      r_ff.st <= smc_pkg::ST_NORMAL;
      r_ff.pendMode <= smc_pkg::MODE_RST;
      r_ff.appMode <= smc_pkg::MODE_RST;
      r_ff.pendWake <= smc_pkg::WAKE_RST;
      r_ff.appWake <= smc_pkg::WAKE_RST;
      r_ff.maskLvl <= smc_pkg::MASK_RST;
      r_ff.lineLvl <= smc_pkg::LEVEL_RST;
      r_ff.cpuClkEn <= 1'b1;
      r_ff.dmaClkEn <= 1'b1;
      r_ff.perClkEn <= 1'b1;
      r_ff.oscEn <= 1'b1;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign pready = r_ff.pready;
  assign pslverr = r_ff.pslverr;
  assign prdata = r_ff.prdata;
  assign cpuClkEn = r_ff.cpuClkEn;
  assign dmaClkEn = r_ff.dmaClkEn;
  assign perClkEn = r_ff.perClkEn;
  assign oscEn = r_ff.oscEn;
  assign busHold = r_ff.busHold;
  assign wdtHold = r_ff.wdtHold;
  assign serviceGo = r_ff.serviceGo;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wakeReturn;
    (r_ff.st == smc_pkg::ST_WAKE) && cpuClkEn && !serviceGo
    ##1 (r_ff.st == smc_pkg::ST_NORMAL) && serviceGo;
  endsequence

  a_entry_needs_req: assert property (
    (r_ff.st == smc_pkg::ST_NORMAL) ##1 (r_ff.st != smc_pkg::ST_NORMAL)
    |-> $past(sleepExec && standbyReqBit))
    else $error("standby entered without request");

  a_idle_wake_seq: assert property (
    (r_ff.st inside {smc_pkg::ST_HALT, smc_pkg::ST_DOZE}) && idleWake |=> s_wakeReturn)
    else $error("idle wake did not return then service");

  a_low_level_stays: assert property (
    (r_ff.st inside {smc_pkg::ST_HALT, smc_pkg::ST_DOZE}) && intReq &&
    (intLevel <= r_ff.maskLvl) && !nmiReq && !rstReq |=> $stable(r_ff.st))
    else $error("low level interrupt woke idle");

  a_halt_bus_hold: assert property (
    (r_ff.st == smc_pkg::ST_HALT) |-> busHold && !dmaClkEn && !cpuClkEn && perClkEn)
    else $error("halt outputs wrong");

  a_doze_bus_free: assert property (
    (r_ff.st == smc_pkg::ST_DOZE) |-> !busHold && dmaClkEn && !cpuClkEn)
    else $error("doze outputs wrong");

  a_stop_holds: assert property (
    (r_ff.st == smc_pkg::ST_STOP) && !stopWake |=> (r_ff.st == smc_pkg::ST_STOP))
    else $error("stop left without a valid source");

  a_stop_ext_wake: assert property (
    (r_ff.st == smc_pkg::ST_STOP) && extHit |=> s_wakeReturn)
    else $error("enabled line failed to wake stop");

  a_stop_clocks_off: assert property (
    (r_ff.st == smc_pkg::ST_STOP) |-> !oscEn && !perClkEn && !cpuClkEn && wdtHold)
    else $error("stop clocks or watchdog wrong");

  a_apply_needs_keys: assert property (
    !$stable(r_ff.appMode) |-> $past(key2Hit))
    else $error("mode applied without unlock");

endmodule : smc_standby_ctrl

// [include/smc_pkg.sv]
package smc_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;    // mode_switch_register
  localparam logic [7:0] ADDR_UNLOCK = 8'h04;  // clock_setting_unlock_register
  localparam logic [7:0] ADDR_WAKE = 8'h08;    // stop wake enables, line 0..3
  localparam logic [7:0] ADDR_MASK = 8'h0C;    // mask_level_register
  localparam logic [7:0] ADDR_LEVEL = 8'h10;   // interrupt_priority_register
  localparam logic [7:0] ADDR_STATUS = 8'h14;  // state and synchronized line values

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int LVL_W = 3;
  localparam int LINES = 4;
  localparam int STATE_LSB = 8;
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_HALT = 2'h1;
  localparam logic [1:0] MODE_DOZE = 2'h2;
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [3:0] WAKE_RST = 4'h0;
  localparam logic [LVL_W-1:0] MASK_RST = 3'h0;
  localparam logic [11:0] LEVEL_RST = 12'h000;

  // ----------------------------------------------------------------
  // Unlock keys and window
  // ----------------------------------------------------------------
  localparam logic [15:0] KEY_FIRST = 16'h5A5A;
  localparam logic [15:0] KEY_SECOND = 16'hF0F0;
  localparam logic [6:0] UNLOCK_WINDOW = 7'h40;  // 64 system clock cycles

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_HALT,
    ST_DOZE,
    ST_STOP,
    ST_WAKE
  } smc_state_e;

  typedef struct packed {
    smc_state_e st;
    logic [1:0] pendMode;
    logic [1:0] appMode;
    logic [3:0] pendWake;
    logic [3:0] appWake;
    logic [LVL_W-1:0] maskLvl;
    logic [11:0] lineLvl;
    logic keyStage;
    logic winOpen;
    logic [6:0] winCnt;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] lineVal;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic cpuClkEn;
    logic dmaClkEn;
    logic perClkEn;
    logic oscEn;
    logic busHold;
    logic wdtHold;
    logic serviceGo;
  } smc_regs_s;

endpackage : smc_pkg

// [sim/smc_far_model.sv]
module smc_far_model (
  input wire logic clk,              // System clock
  input wire logic serviceGo,        // Core starts servicing
  output logic standbyReqBit,        // Standby request bit
  output logic sleepExec,            // Sleep instruction pulse
  output logic intReq,               // Maskable request
  output logic [2:0] intLevel,       // Level of that request
  output logic nmiReq,               // Nonmaskable request
  output logic nmiFromWdt,           // NMI raised by watchdog
  output logic rstReq,               // Reset request
  output logic rstFromWdt,           // Reset raised by watchdog
  output logic [3:0] extIntLine      // External pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Core, interrupt controller and pins
  // ------------------------------------------------------------
  initial
  begin
    {standbyReqBit, sleepExec, intReq, intLevel} = '0;
    {nmiReq, nmiFromWdt, rstReq, rstFromWdt, extIntLine} = '0;
  end

  // Request bit and the one-cycle sleep pulse on the same edge
  task sleep_now();
    @(posedge clk);
    standbyReqBit <= 1'b1;
    sleepExec <= 1'b1;
    @(posedge clk);
    sleepExec <= 1'b0;
  endtask : sleep_now

  // Wake sources; the caller picks levels above the mask when it wants a wake
  task drive(input logic irq, input logic [2:0] lvl, input logic nmi, input logic rst,
             input logic wdt, input logic [3:0] pins);
    @(posedge clk);
    intReq <= irq;
    intLevel <= lvl;
    nmiReq <= nmi;
    rstReq <= rst;
    nmiFromWdt <= wdt;
    rstFromWdt <= wdt;
    extIntLine <= pins;
  endtask : drive

  // Servicing acknowledges the source, so requests drop
  always @(posedge clk)
  begin
    if (serviceGo === 1'b1)
    begin
      {standbyReqBit, intReq, nmiReq, rstReq, extIntLine} <= '0;
    end
  end
endmodule : smc_far_model

// [sim/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, serviceGo;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sbr, slp, irq, nmi, nmiW, rq, rqW;
  logic [2:0] lvl, mask;
  logic [3:0] pins;
  logic cpuE, dmaE, perE, oscE, bh, wh;
  logic [32:0] expq[$];
  logic [32:0] e;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 86;

  smc_standby_ctrl u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .standbyReqBit(sbr), .sleepExec(slp), .intReq(irq), .intLevel(lvl),
    .nmiReq(nmi), .nmiFromWdt(nmiW), .rstReq(rq), .rstFromWdt(rqW), .extIntLine(pins),
    .cpuClkEn(cpuE), .dmaClkEn(dmaE), .perClkEn(perE), .oscEn(oscE), .busHold(bh),
    .wdtHold(wh), .serviceGo(serviceGo));

  smc_far_model u_far (.clk(clk), .serviceGo(serviceGo), .standbyReqBit(sbr),
    .sleepExec(slp), .intReq(irq), .intLevel(lvl), .nmiReq(nmi), .nmiFromWdt(nmiW),
    .rstReq(rq), .rstFromWdt(rqW), .extIntLine(pins));

  // ------------------------------------------------------------
  // Clock, timeout and checking
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Run needs about 300 cycles; generous ceiling
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      test_done();
    end
  end

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    checked++;
    if (g !== ex)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk

  // Oldest expected read result against each completed read
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e = expq.pop_front();
      chk("prdata", e[31:0], prdata);
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
    end
  end

  task test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // APB master and helpers
  // ------------------------------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [32:0] ex);
    expq.push_back(ex);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Stage mode and wake enables, then first and second key in back-to-back writes
  task cfg(input logic [1:0] m, input logic [3:0] w);
    apb(1'b1, smc_pkg::ADDR_MODE, {30'h0, m});
    apb(1'b1, smc_pkg::ADDR_WAKE, {28'h0, w});
    apb(1'b1, smc_pkg::ADDR_UNLOCK, {16'h0000, smc_pkg::KEY_FIRST});
    apb(1'b1, smc_pkg::ADDR_UNLOCK, {16'h0000, smc_pkg::KEY_SECOND});
  endtask : cfg

  // Order: cpu, dma, peripheral, oscillator, busHold, wdtHold
  task en(input logic [5:0] ex);
    chk("clkEnables", {26'h0, ex}, {26'h0, cpuE, dmaE, perE, oscE, bh, wh});
  endtask : en

  // No-wake cases need the full wait; a wake is seen within the sync latency
  task go(input logic w);
    int n;
    logic s;
    n = 0;
    s = 1'b0;
    while (n < 12 && !s)
    begin
      @(posedge clk);
      s = (serviceGo === 1'b1);
      n++;
    end
    chk("serviceGo", {31'h0, w}, {31'h0, s});
    if (w) en(6'h3C);
  endtask : go

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    mask = 3'($unsigned($random(seed)) % 6);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(smc_pkg::ADDR_MODE, {31'h0, smc_pkg::MODE_RST});
    rd(smc_pkg::ADDR_STATUS, 33'h0);
    rd(8'h18, {1'b1, 32'h0});
    en(6'h3C);
    apb(1'b1, smc_pkg::ADDR_MASK, {29'h0, mask});
    apb(1'b1, smc_pkg::ADDR_LEVEL, {23'h0, mask + 3'h1, mask + 3'h2, mask});
    cfg(smc_pkg::MODE_DOZE, 4'h5);
    rd(smc_pkg::ADDR_MODE, {31'h0, smc_pkg::MODE_DOZE});
    rd(smc_pkg::ADDR_WAKE, 33'h5);
    apb(1'b1, smc_pkg::ADDR_MODE, {30'h0, smc_pkg::MODE_STOP});
    repeat (70) @(posedge clk);
    apb(1'b1, smc_pkg::ADDR_UNLOCK, {16'h0000, smc_pkg::KEY_FIRST});
    apb(1'b1, smc_pkg::ADDR_UNLOCK, {16'h0000, smc_pkg::KEY_SECOND});
    rd(smc_pkg::ADDR_MODE, {31'h0, smc_pkg::MODE_DOZE});
    $display("test registers done");
    u_far.sleep_now();
    repeat (2) @(posedge clk);
    en(6'h1C);
    rd(smc_pkg::ADDR_STATUS, 33'h200);
    u_far.drive(1'b1, mask, 1'b0, 1'b0, 1'b0, 4'h0);
    go(1'b0);
    u_far.drive(1'b1, mask + 3'h1, 1'b0, 1'b0, 1'b0, 4'h0);
    go(1'b1);
    $display("test doze done");
    cfg(smc_pkg::MODE_HALT, 4'h5);
    u_far.sleep_now();
    repeat (2) @(posedge clk);
    en(6'h0E);
    u_far.drive(1'b0, 3'h0, 1'b1, 1'b0, 1'b1, 4'h0);
    go(1'b1);
    $display("test halt done");
    cfg(smc_pkg::MODE_STOP, 4'h5);
    u_far.sleep_now();
    repeat (2) @(posedge clk);
    en(6'h01);
    u_far.drive(1'b0, 3'h0, 1'b1, 1'b1, 1'b1, 4'h0);
    go(1'b0);
    u_far.drive(1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 4'h2);
    go(1'b0);
    u_far.drive(1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 4'h1);
    go(1'b0);
    u_far.drive(1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 4'h4);
    go(1'b1);
    // Released pins need the sync latency before status reads them low
    repeat (6) @(posedge clk);
    rd(smc_pkg::ADDR_STATUS, 33'h0);
    $display("test stop done");
    // Unused mode code: sleep must leave the device running
    cfg(2'h3, 4'h0);
    u_far.sleep_now();
    repeat (2) @(posedge clk);
    rd(smc_pkg::ADDR_STATUS, 33'h0);
    en(6'h3C);
    $display("test no-mode done");
    test_done();
  end
endmodule : tb_top
